// ==== bench/scbp_audio_partner.sv ====
// Behavioural audio processor: word clocks and block start drive
`timescale 1ns/1ps
`default_nettype none
module scbp_audio_partner (
  // Bench request for a block start
  input wire logic blkReq,
  // Word clocks, free running as studio clocks are
  output logic wordSelect,
  output logic extWordClock,
  // Block start drive onto the shared pin
  output logic blockDrv
);
  // Offset keeps word select edges clear of the system clock edges; external clock edges drift across them
  initial begin
    wordSelect = 1'b0;
    #1.3;
    forever #62.5 wordSelect = ~wordSelect;
  end
  initial begin
    extWordClock = 1'b0;
    #3.1;
    forever #64.1 extWordClock = ~extWordClock;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Held across two word periods, well over one sub-frame
  initial begin
    blockDrv = 1'b0;
    forever begin
      @(posedge blkReq);
      @(negedge wordSelect);
      blockDrv = 1'b1;
      repeat (2) @(negedge wordSelect);
      blockDrv = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the subcode bit port
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import scbp_pkg::*;
;
  logic clk_sys, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic s_axi_bready, s_axi_rready, controlStyleSelect, validityInPin;
  logic rxLocked, rxBlockBit, rxStatusBit, rxUserBit, rxValidityBit;
  logic auxAudioInBlock, auxAudioInStatus, auxAudioInUser, auxAudioInValidity;
  logic blkReq, drvStatus, drvUser, fs, fu, fv, fa;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rdat, txWord, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] resp;
  logic [191:0] rxBits;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire wordSelect, extWordClock, blockDrv, blockPinIn, statusPinIn, userPinIn;
  wire blockPinOut, blockPinOe, statusPinOut, statusPinOe, userPinOut;
  wire userPinOe, validityOutPin, txBlockStart, txStatusSub1, txStatusSub2;
  wire txUserBit, txValidityBit;
  wire [2:0] serialAudioOutSubcode;
  int bad_count, check_count, i;

  // Each subcode pin carries whichever side drives it
  assign blockPinIn = blockPinOe ? blockPinOut : blockDrv;
  assign statusPinIn = statusPinOe ? statusPinOut : drvStatus;
  assign userPinIn = userPinOe ? userPinOut : drvUser;

  scbp_subcode_port dut (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .wordSelect, .extWordClock,
    .controlStyleSelect, .blockPinIn, .blockPinOut, .blockPinOe,
    .statusPinIn, .statusPinOut, .statusPinOe, .userPinIn, .userPinOut,
    .userPinOe, .validityInPin, .validityOutPin, .rxLocked, .rxBlockBit,
    .rxStatusBit, .rxUserBit, .rxValidityBit, .auxAudioInBlock,
    .auxAudioInStatus, .auxAudioInUser, .auxAudioInValidity,
    .serialAudioOutSubcode, .txBlockStart, .txStatusSub1, .txStatusSub2,
    .txUserBit, .txValidityBit);
  scbp_audio_partner peer (.blkReq, .wordSelect, .extWordClock, .blockDrv);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic ready(input int k);
    case (k)
      0: return s_axi_awready & s_axi_wready;
      1: return s_axi_bvalid;
      2: return s_axi_arready;
      default: return s_axi_rvalid;
    endcase
  endfunction

  // Returns at a falling edge with the awaited signal seen high
  task automatic waitFor(input int k);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (ready(k) !== 1'b1) begin
      n++;
      if (n > 200) begin
        bad_count++;
        wrap_up();
      end
      @(negedge clk_sys);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    waitFor(0);
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    waitFor(1);
    resp = s_axi_bresp;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    waitFor(2);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    waitFor(3);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk_sys);
  endtask

  // Presents one frame of received and aux bits at the word clock rise
  task automatic frame(input logic blk);
    int n;
    n = 0;
    while (wordSelect === 1'b1 && n < 40) begin
      n++;
      @(posedge clk_sys);
    end
    while (wordSelect !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 40) begin
      bad_count++;
      wrap_up();
    end
    r = $urandom;
    {fs, fu, fv, fa} = r[3:0];
    rxBlockBit <= blk;
    rxStatusBit <= fs;
    rxUserBit <= fu;
    rxValidityBit <= fv;
    auxAudioInStatus <= fa;
    auxAudioInUser <= fa;
    auxAudioInValidity <= fa;
    blkReq <= 1'b0;
    repeat (7) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Consumer stereo code overrides bits 20 to 23
  function automatic logic csExp(input int k, input logic sub2);
    if (k >= 20 && k < 24)
      return k == (sub2 ? 21 : 20);
    return txWord[k] | drvStatus;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, blkReq} = 4'h0;
    {controlStyleSelect, validityInPin, rxLocked, rxBlockBit} = 4'h0;
    {rxStatusBit, rxUserBit, rxValidityBit, drvStatus, drvUser} = 5'h00;
    {auxAudioInBlock, auxAudioInStatus, auxAudioInUser} = 3'h0;
    auxAudioInValidity = 1'b0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_wstrb = 4'hF;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    rstn = 1'b0;
    void'($urandom(32'h55250E91));
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(REG_CTRL);
    chk(rdat, {20'h0, CTRL_RESET}, "ctrl reset");
    rd(8'h30);
    chk(resp, RESP_SLVERR, "unmapped read");
    wr(8'hF0, 32'h1);
    chk(resp, RESP_SLVERR, "unmapped write");
    $display("Test registers done");
    rxLocked <= 1'b1;
    wr(REG_CTRL, 32'h3);
    for (i = 0; i < 193; i++) begin
      frame(i == 0);
      rxBits[i % 192] = fs;
      chk(blockPinOut, (i % 192) < 40, "block out");
      chk({statusPinOut, userPinOut, validityOutPin}, {fs, fu, fv},
          "pins out");
      chk({blockPinOe, txUserBit, serialAudioOutSubcode}, 5'h10,
          "oe, user, lane");
      if (i == 100)
        wr(REG_CTRL, 32'h23);
    end
    rd(REG_CTRL);
    chk(rdat, 32'h3, "copy request");
    for (i = 0; i < 6; i++) begin
      rd(REG_RXCS + 8'(4 * i));
      chk(rdat, rxBits[32 * i +: 32], "rx status");
      rd(REG_TXCS + 8'(4 * i));
      chk(rdat | (i == 0), rxBits[32 * i +: 32] | (i == 0), "copy");
    end
    rd(REG_STAT);
    chk(rdat[0], fv, "rx validity flag");
    $display("Test block output done");
    wr(REG_CTRL, 32'h843);
    for (i = 0; i < 4; i++) begin
      rxLocked <= (i < 2);
      frame(1'b0);
      chk(txUserBit, fu & (i < 2), "user loop");
      if (i >= 2)
        chk({blockPinOut, statusPinOut, userPinOut, validityOutPin}, 4'h0,
            "fallback");
    end
    $display("Test fallback done");
    rxLocked <= 1'b1;
    controlStyleSelect <= 1'b1;
    validityInPin <= 1'b1;
    wr(REG_CTRL, 32'h40);
    frame(1'b0);
    frame(1'b0);
    chk({blockPinOe, txUserBit, txValidityBit}, 3'h5, "strap");
    controlStyleSelect <= 1'b0;
    validityInPin <= 1'b0;
    $display("Test strap done");
    txWord = $urandom & 32'hFFFF_FFFE;
    wr(REG_TXCS, txWord);
    wr(REG_CTRL, 32'h1A);
    frame(1'b0);
    blkReq <= 1'b1;
    for (i = 0; i < 32; i++) begin
      frame(1'b0);
      chk(txStatusSub1, csExp(i, 1'b0), "tx status 1");
      chk(txStatusSub2, csExp(i, 1'b1), "tx status 2");
      chk({txUserBit, txValidityBit}, {drvUser, validityInPin | (i > 16)},
          "user, validity in");
      if (i == 16)
        wr(REG_CTRL, 32'h9A);
      r = $urandom;
      drvStatus <= r[0] & (i < 19 || i > 22);
      drvUser <= r[1];
      validityInPin <= r[2];
    end
    $display("Test pins in done");
    wr(REG_CTRL, 32'h203);
    for (i = 0; i < 8; i++) begin
      frame(1'b0);
      chk(serialAudioOutSubcode, {fs, fu, fv}, "serial lane");
      chk({txUserBit, txValidityBit}, {fa, fa}, "aux bits");
    end
    $display("Test aux stream done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== verilog/scbp_crc8.sv ====
// Serial block CRC generator, one bit per frame
`timescale 1ns/1ps
`default_nettype none
module scbp_crc8
  import scbp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstnInt,
  // Control
  input wire logic shiftEn,
  input wire logic restart,
  input wire logic outMode,
  input wire logic dataBit,
  // Result, most significant bit first
  output logic crcBit
);
  logic [7:0] crc_q;
  logic [7:0] base;
  logic fb;

  assign base = restart ? CRC_INIT : crc_q;
  assign fb = base[7] ^ dataBit;
  assign crcBit = crc_q[7];

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      crc_q <= CRC_INIT;
    end else if (shiftEn) begin
      if (outMode) begin
        crc_q <= {crc_q[6:0], 1'b0};
      end else begin
        crc_q <= {base[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/scbp_pkg.sv ====
// Constants for the subcode bit port: register map, fields, frame counts
package scbp_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RXCS = 8'h40;
  localparam logic [7:0] REG_TXCS = 8'h80;
  localparam logic [2:0] CS_WORDS = 3'h6;
  // Control register field positions
  localparam int CTRL_DIR = 0;
  localparam int CTRL_PIN_EN = 1;
  localparam int CTRL_TX_SRC = 2;
  localparam int CTRL_CRC_EN = 3;
  localparam int CTRL_STEREO = 4;
  localparam int CTRL_COPY = 5;
  localparam int CTRL_LOOP = 6;
  localparam int CTRL_VTX = 7;
  localparam int CTRL_INDEPENDENT_RATE_MODE = 8;
  localparam int CTRL_AES3 = 9;
  localparam int CTRL_CM_LSB = 10;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RESET = 12'h002;
  localparam logic [1:0] CM_FALLBACK = 2'h2;
  // Status register field positions
  localparam int STAT_VRX = 0;
  localparam int STAT_LOCK = 1;
  localparam int STAT_COPY = 2;
  localparam int STAT_IDX_LSB = 8;
  // Frame positions inside a 192-frame block
  localparam logic [7:0] FRAME_LAST = 8'hBF;
  localparam logic [7:0] BLOCK_HIGH_LAST = 8'h27;
  localparam logic [7:0] CHAN_LEFT = 8'h14;
  localparam logic [7:0] CHAN_RIGHT = 8'h15;
  localparam logic [7:0] CHAN_LAST = 8'h17;
  localparam logic [7:0] CRC_FIRST = 8'hB8;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [191:0] TXCS_DEFAULT = 192'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin synchroniser lanes
  localparam int PIN_B = 0;
  localparam int PIN_C = 1;
  localparam int PIN_U = 2;
  localparam int PIN_V = 3;
  localparam int PIN_WS = 4;
  localparam int PIN_EWC = 5;
  localparam int PIN_STRAP = 6;
  localparam int PIN_W = 7;
endpackage

// ==== verilog/scbp_subcode_port.sv ====
// Block start, channel status, user and validity handling with AXI4-Lite
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Operation
// - Direction bit makes subcode pins outputs or inputs
// - Unlocked in clock mode 2, direction out: pins low
// - Received status kept in 192-bit buffer
// - Output pins show received status per frame
// - Input pins: status is buffer OR pin
// - AES3: status from aux or buffer
// - Professional with CRC enable: generate CRC
// - Consumer bits 20-23 follow stereo code enable
// - Copy request moves rx buffer at block start
// - Output pins show received user bits
// - Synchronous outputs: user zero or loopback when locked
// - AES3: received bits ride serial output; aux user
// - Received validity on pin and flag
// - Transmit validity is pin OR flag; pin ignored for asynchronous inputs, flag when strapped
// - AES3: transmit validity from aux stream
// - Frame timing from word select or external clock
// - Block start output high frames 0 to 39
// - AES3: block timing from aux block bit
// - Strapped control: outputs, default status, zero user
// - Independent rate mode selects the frame clock
module scbp_subcode_port
  import scbp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AXI4-Lite register slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Frame clocks and strap pin
  input wire logic wordSelect,
  input wire logic extWordClock,
  input wire logic controlStyleSelect,
  // Subcode pins
  input wire logic blockPinIn,
  output logic blockPinOut,
  output logic blockPinOe,
  input wire logic statusPinIn,
  output logic statusPinOut,
  output logic statusPinOe,
  input wire logic userPinIn,
  output logic userPinOut,
  output logic userPinOe,
  input wire logic validityInPin,
  output logic validityOutPin,
  // Recovered receive bits
  input wire logic rxLocked,
  input wire logic rxBlockBit,
  input wire logic rxStatusBit,
  input wire logic rxUserBit,
  input wire logic rxValidityBit,
  // Aux audio input subcode bits
  input wire logic auxAudioInBlock,
  input wire logic auxAudioInStatus,
  input wire logic auxAudioInUser,
  input wire logic auxAudioInValidity,
  // Serial audio out subcode lane: status, user, validity
  output logic [2:0] serialAudioOutSubcode,
  // Transmit frame bits
  output logic txBlockStart,
  output logic txStatusSub1,
  output logic txStatusSub2,
  output logic txUserBit,
  output logic txValidityBit
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] rstSync_q;
  logic rstnInt;
  logic [PIN_W-1:0] pinSync;
  logic [11:0] ctrl_q, ctrl_d;
  logic [191:0] rxBuf_q, txBuf_q;
  logic [7:0] idx_q, idxNow, idxInc;
  logic linkPrev_q, bPrev_q;
  logic cOut_q, uOut_q, validity_out_pin_q, proBit_q;
  logic txA_q, txB_q, txU_q, txV_q, txBlk_q;
  logic [2:0] serial_audio_out_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_q[1];

  scbp_sync #(.W(PIN_W)) uPinSync (
    .clk_sys(clk_sys),
    .rstnInt(rstnInt),
    .d({controlStyleSelect, extWordClock, wordSelect, validityInPin,
        userPinIn, statusPinIn, blockPinIn}),
    .q(pinSync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Effective modes; strapping overrides the direction, pin enable, AES3 and rate settings, not the clock mode
  wire strap = pinSync[PIN_STRAP];
  wire dirOut = ctrl_q[CTRL_DIR] | strap;
  wire pinEn = ctrl_q[CTRL_PIN_EN] | strap;
  wire aes3 = ctrl_q[CTRL_AES3] & ~strap;
  wire asyncMode = ctrl_q[CTRL_INDEPENDENT_RATE_MODE] & ~strap;
  wire fallbackLow = (ctrl_q[CTRL_CM_LSB +: 2] == CM_FALLBACK) & ~rxLocked;
  wire pinDrive = pinEn & ~fallbackLow;

  // Frame tick on the rising edge of the selected frame clock
  wire frameClk = asyncMode ? pinSync[PIN_EWC] : pinSync[PIN_WS];
  wire tick = frameClk & ~linkPrev_q;
  wire bRise = pinSync[PIN_B] & ~bPrev_q;

  // Block start source
  wire blkEvt = aes3 ? auxAudioInBlock :
    (dirOut ? (rxBlockBit & ~asyncMode) : bRise);
  assign idxInc = (idx_q == FRAME_LAST) ? 8'h00 : 8'(idx_q + 8'h01);
  assign idxNow = blkEvt ? 8'h00 : idxInc;
  wire blkStart = tick & (idxNow == 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // Transmit channel status
  wire [191:0] txSrcBuf = strap ? TXCS_DEFAULT : txBuf_q;
  wire cPinUse = ~dirOut & ~aes3 & pinSync[PIN_C];
  wire useAux = aes3 & ~ctrl_q[CTRL_TX_SRC];
  wire srcBit = useAux ? auxAudioInStatus :
    (txSrcBuf[idxNow] | cPinUse);
  wire proNow = (idxNow == 8'h00) ? srcBit : proBit_q;
  wire crcZone = idxNow >= CRC_FIRST;
  wire crcAct = ctrl_q[CTRL_CRC_EN] & proNow & crcZone;
  wire chanZone = ~proNow & (idxNow >= CHAN_LEFT) & (idxNow <= CHAN_LAST);
  wire stereo = ctrl_q[CTRL_STEREO];
  wire crcBit;
  wire statA = crcAct ? crcBit :
    (chanZone ? (stereo & (idxNow == CHAN_LEFT)) : srcBit);
  wire statB = crcAct ? crcBit :
    (chanZone ? (stereo & (idxNow == CHAN_RIGHT)) : srcBit);

  scbp_crc8 uCrc (
    .clk_sys(clk_sys),
    .rstnInt(rstnInt),
    .shiftEn(tick & (idxNow == 8'h00 | proBit_q)),
    .restart(idxNow == 8'h00),
    .outMode(crcZone),
    .dataBit(statA),
    .crcBit(crcBit)
  );

  // Transmit user and validity
  wire loopUser = ctrl_q[CTRL_LOOP] & ~asyncMode & rxLocked & rxUserBit;
  wire userSel = aes3 ? auxAudioInUser :
    (strap ? 1'b0 :
    (dirOut ? loopUser : pinSync[PIN_U]));
  wire vPinUse = pinSync[PIN_V] & ~(asyncMode & ~dirOut);
  wire validSel = aes3 ? auxAudioInValidity :
    (vPinUse | (ctrl_q[CTRL_VTX] & ~strap));

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      linkPrev_q <= 1'b0;
      bPrev_q <= 1'b0;
      idx_q <= 8'h00;
      proBit_q <= 1'b0;
    end else begin
      linkPrev_q <= frameClk;
      if (tick) begin
        bPrev_q <= pinSync[PIN_B];
        idx_q <= idxNow;
        proBit_q <= proNow;
      end
    end
  end

  // Receive capture and transmit bits, together with the current sample
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      rxBuf_q <= 192'h0;
      cOut_q <= 1'b0;
      uOut_q <= 1'b0;
      validity_out_pin_q <= 1'b0;
      serial_audio_out_q <= 3'h0;
      {txBlk_q, txA_q, txB_q, txU_q, txV_q} <= 5'h00;
    end else if (tick) begin
      rxBuf_q[idxNow] <= rxStatusBit;
      cOut_q <= rxStatusBit;
      uOut_q <= rxUserBit;
      validity_out_pin_q <= rxValidityBit;
      serial_audio_out_q <= aes3 ? {rxStatusBit, rxUserBit, rxValidityBit} : 3'h0;
      txBlk_q <= idxNow == 8'h00;
      txA_q <= statA;
      txB_q <= statB;
      txU_q <= userSel;
      txV_q <= validSel;
    end
  end

  assign serialAudioOutSubcode = serial_audio_out_q;
  assign txBlockStart = txBlk_q;
  assign txStatusSub1 = txA_q;
  assign txStatusSub2 = txB_q;
  assign txUserBit = txU_q;
  assign txValidityBit = txV_q;

  // Pins: enables follow direction; block, status and user outputs forced low when not driving
  assign blockPinOe = dirOut;
  assign statusPinOe = dirOut;
  assign userPinOe = dirOut;
  assign blockPinOut = pinDrive & dirOut & (idx_q <= BLOCK_HIGH_LAST);
  assign statusPinOut = pinDrive & dirOut & cOut_q;
  assign userPinOut = pinDrive & dirOut & uOut_q;
  assign validityOutPin = ~(dirOut & fallbackLow) & validity_out_pin_q;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken together, answer next cycle
  function automatic logic csHit(input logic [7:0] a, input logic [7:0] b);
    csHit = (a[7:5] == b[7:5]) && (a[4:2] < CS_WORDS) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] rdWord(input logic [7:0] a);
    logic [7:0] sel;
    sel = {a[4:2], 5'h00};
    rdWord = 32'h0;
    if (a == REG_CTRL) begin
      rdWord = {20'h0, ctrl_q};
    end else if (a == REG_STAT) begin
      rdWord = {16'h0, idx_q, 5'h00, ctrl_q[CTRL_COPY], rxLocked, validity_out_pin_q};
    end else if (csHit(a, REG_RXCS)) begin
      rdWord = rxBuf_q[sel +: 32];
    end else if (csHit(a, REG_TXCS)) begin
      rdWord = txBuf_q[sel +: 32];
    end
  endfunction

  wire wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire rdTake = s_axi_arvalid & ~rvalid_q;
  wire wrCtrl = wrTake & (s_axi_awaddr == REG_CTRL);
  wire wrTx = wrTake & csHit(s_axi_awaddr, REG_TXCS);
  wire wrOk = wrCtrl | wrTx | (s_axi_awaddr == REG_STAT) |
    csHit(s_axi_awaddr, REG_RXCS);
  wire rdOk = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_STAT) |
    csHit(s_axi_araddr, REG_RXCS) | csHit(s_axi_araddr, REG_TXCS);
  wire [31:0] wMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  logic [31:0] wWord;
  // Process form so the merge also follows register contents, not just args
  always_comb begin
    wWord = (rdWord(s_axi_awaddr) & ~wMask) | (s_axi_wdata & wMask);
  end
  wire [7:0] wSel = {s_axi_awaddr[4:2], 5'h00};
  wire copyNow = ctrl_q[CTRL_COPY] & blkStart;

  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_arready = rdTake;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Software writing the request bit wins over the hardware clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (copyNow) begin
      ctrl_d[CTRL_COPY] = 1'b0;
    end
    if (wrCtrl) begin
      ctrl_d = wWord[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      ctrl_q <= CTRL_RESET;
      txBuf_q <= TXCS_DEFAULT;
    end else begin
      ctrl_q <= ctrl_d;
      if (copyNow) begin
        txBuf_q <= rxBuf_q;
      end else if (wrTx) begin
        txBuf_q[wSel +: 32] <= wWord;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      if (wrTake) begin
        bvalid_q <= 1'b1;
        bresp_q <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rdTake) begin
        rvalid_q <= 1'b1;
        rresp_q <= rdOk ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= rdWord(s_axi_araddr);
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_pinDir;
    @(posedge clk_sys) disable iff (!rstnInt)
    $rose(ctrl_q[CTRL_DIR]) |-> blockPinOe && statusPinOe && userPinOe;
  endproperty
  a_pinDir: assert property (p_pinDir)
    else $error("subcode pins not outputs after direction set");

  property p_unlockLow;
    @(posedge clk_sys) disable iff (!rstnInt)
    dirOut && fallbackLow |->
      !blockPinOut && !statusPinOut && !userPinOut && !validityOutPin;
  endproperty
  a_unlockLow: assert property (p_unlockLow)
    else $error("pins not low while unlocked in fallback mode");

  property p_copy;
    @(posedge clk_sys) disable iff (!rstnInt)
    copyNow && !wrCtrl |=> txBuf_q == $past(rxBuf_q) && !ctrl_q[CTRL_COPY];
  endproperty
  a_copy: assert property (p_copy)
    else $error("status copy not applied at block start");

  property p_blockHigh;
    @(posedge clk_sys) disable iff (!rstnInt)
    tick && idxNow == 8'h00 && dirOut && !fallbackLow && pinEn
      |=> blockPinOut [*2];
  endproperty
  a_blockHigh: assert property (p_blockHigh)
    else $error("block start output not high in frame 0");

  property p_frameWrap;
    @(posedge clk_sys) disable iff (!rstnInt)
    tick && !blkEvt && idx_q == FRAME_LAST |=> idx_q == 8'h00;
  endproperty
  a_frameWrap: assert property (p_frameWrap)
    else $error("frame index did not wrap after 192 frames");

  property p_rxValid;
    @(posedge clk_sys) disable iff (!rstnInt)
    tick |=> validity_out_pin_q == $past(rxValidityBit) ##1 $stable(validity_out_pin_q) || tick;
  endproperty
  a_rxValid: assert property (p_rxValid)
    else $error("received validity not captured at frame tick");

  property p_stereo;
    @(posedge clk_sys) disable iff (!rstnInt)
    tick && !proNow && stereo && idxNow == CHAN_LEFT |=> txA_q && !txB_q;
  endproperty
  a_stereo: assert property (p_stereo)
    else $error("stereo code bit 20 wrong");

  property p_auxValid;
    @(posedge clk_sys) disable iff (!rstnInt)
    tick && aes3 |=> txV_q == $past(auxAudioInValidity);
  endproperty
  a_auxValid: assert property (p_auxValid)
    else $error("aux validity not used in AES3 mode");

  property p_vtxOr;
    @(posedge clk_sys) disable iff (!rstnInt)
    tick && !aes3 && !strap && ctrl_q[CTRL_VTX] |=> txV_q;
  endproperty
  a_vtxOr: assert property (p_vtxOr)
    else $error("validity flag not ORed into transmit validity");

  property p_userZero;
    @(posedge clk_sys) disable iff (!rstnInt)
    tick && !aes3 && dirOut && !asyncMode && !ctrl_q[CTRL_LOOP] |=> !txU_q;
  endproperty
  a_userZero: assert property (p_userZero)
    else $error("transmit user bit not zero without loopback");
endmodule
`default_nettype wire

// ==== verilog/scbp_sync.sv ====
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module scbp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstnInt,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire
